// file: mic_consts.vh
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH
`define MIC_SP_CODE 2'h0
`define MIC_SP_XDATA 2'h1
`define MIC_SP_DIR 2'h2
`define MIC_SP_IND 2'h3
`define MIC_T_XR0 3'h0
`define MIC_T_XR1 3'h1
`define MIC_T_IRAM 3'h2
`define MIC_T_FL 3'h3
`define MIC_T_SFR 3'h4
`define MIC_T_EXTRA_PROCESSOR_REGISTER_WINDOW 3'h5
`define MIC_T_RAD 3'h6
`define MIC_T_NONE 3'h7
`define MIC_WIN_MASK 16'hF000
`define MIC_XR0_BASE 16'h0000
`define MIC_XR1_BASE 16'h1000
`define MIC_RAD_BASE 16'h4000
`define MIC_RADNB_BASE 16'h5000
`define MIC_SFRX_MASK 16'hFF80
`define MIC_SFRX_BASE 16'h7080
`define MIC_EXTRA_PROCESSOR_REGISTER_WINDOW_BASE 16'h7100
`define MIC_ERASE_REG 16'h7F00
`define MIC_FLX_BASE 16'h8000
`define MIC_XRAM_AW 11
`define MIC_IRAM_AW 7
`define MIC_PAGE_W 6
`define MIC_RR_RST 2'h2
`define MIC_C_IDLE 3'h1
`define MIC_C_DEM 3'h2
`define MIC_C_PRE 3'h4
`endif

// file: mic_rr_arb.v
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.vh"
module mic_rr_arb (
  input wire clock_in,
  input wire rst_n_in,
  input wire [2:0] req_in,
  input wire adv_in,
  output reg [2:0] gnt_out
);
  reg [1:0] last_ff;
  reg held_ff;
  reg [2:0] own_ff;
  reg [1:0] idx;
  reg [2:0] pick;
  integer k;

  function [1:0] nxt3;
    input [1:0] x;
    nxt3 = (x == 2'h2) ? 2'h0 : x + 2'h1;
  endfunction

  // search starts after last winner, so a waiter is served within two grants
  always @* begin
    pick = 3'h0;
    idx = last_ff;
    for (k = 0; k < 3; k = k + 1) begin
      idx = nxt3(idx);
      if (pick == 3'h0 && req_in[idx]) pick[idx] = 1'b1;
    end
    // a multi-cycle access keeps its owner even if a closer master shows up
    gnt_out = held_ff ? own_ff : pick;
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_ff <= `MIC_RR_RST;
      held_ff <= 1'b0;
      own_ff <= 3'h0;
    end else begin
      held_ff <= (|gnt_out) & ~adv_in;
      own_ff <= gnt_out;
      if (adv_in) begin
        last_ff <= gnt_out[2] ? 2'h2 : (gnt_out[1] ? 2'h1 : 2'h0);
      end
    end
  end
endmodule // mic_rr_arb
`default_nettype wire

// file: mic_flash_cache.v
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.vh"
module mic_flash_cache (
  input wire clock_in,
  input wire rst_n_in,
  input wire rd_in,
  input wire [14:0] addr_in,
  input wire inval_in,
  output reg hit_out,
  output reg [15:0] data_out,
  output wire idle_out,
  output wire fl_rd_out,
  output wire [14:0] fl_addr_out,
  input wire [15:0] fl_rdata_in,
  input wire fl_valid_in
);
  localparam ST_IDLE = `MIC_C_IDLE;
  localparam ST_DEM = `MIC_C_DEM;
  localparam ST_PRE = `MIC_C_PRE;
  reg [14:0] tag_ff [0:3];
  reg [15:0] dat_ff [0:3];
  reg [3:0] vld_ff;
  reg [1:0] rep_ff;
  reg [2:0] st_ff;
  reg rd_ff;
  reg [14:0] addr_ff;
  reg pf_hit;
  wire [14:0] pf_addr = addr_ff + 15'h0001;
  integer i;

  always @* begin
    hit_out = 1'b0;
    data_out = 16'h0000;
    pf_hit = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (vld_ff[i] && tag_ff[i] == addr_in) begin
        hit_out = 1'b1;
        data_out = dat_ff[i];
      end
      if (vld_ff[i] && tag_ff[i] == pf_addr) pf_hit = 1'b1;
    end
  end

  assign idle_out = (st_ff == ST_IDLE);
  assign fl_rd_out = rd_ff;
  assign fl_addr_out = addr_ff;

  always @(posedge clock_in) begin
    if (st_ff != ST_IDLE && fl_valid_in) begin
      tag_ff[rep_ff] <= addr_ff;
      dat_ff[rep_ff] <= fl_rdata_in;
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vld_ff <= 4'h0;
      rep_ff <= 2'h0;
      st_ff <= ST_IDLE;
      rd_ff <= 1'b0;
      addr_ff <= 15'h0000;
    end else begin
      rd_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (rd_in && !hit_out) begin
            rd_ff <= 1'b1;
            addr_ff <= addr_in;
            st_ff <= ST_DEM;
          end
        end
        ST_DEM, ST_PRE: begin
          if (fl_valid_in) begin
            vld_ff[rep_ff] <= 1'b1;
            rep_ff <= rep_ff + 2'h1;
            // fetch the next word behind a demand miss, sequential code wins most
            if (st_ff == ST_DEM && !pf_hit) begin
              rd_ff <= 1'b1;
              addr_ff <= pf_addr;
              st_ff <= ST_PRE;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      // a fill landing with an invalidate is dropped as stale
      if (inval_in) vld_ff <= 4'h0;
    end
  end
endmodule // mic_flash_cache
`default_nettype wire

// file: mic_interconnect.v
`timescale 1ns/10ps
`default_nettype none
`include "mic_consts.vh"
module mic_interconnect (
  input wire clock_in,
  input wire rst_n_in,
  input wire [2:0] mst_req_in,
  input wire [2:0] mst_we_in,
  input wire [1:0] mst_wide_in,
  input wire [5:0] mst_space_in,
  input wire [47:0] mst_addr_in,
  input wire [47:0] mst_wdata_in,
  output wire [2:0] mst_ack_out,
  output wire [47:0] mst_rdata_out,
  input wire [1:0] ram_off_in,
  output wire sfr_stb_out,
  output wire sfr_we_out,
  output wire [7:0] sfr_addr_out,
  output wire [7:0] sfr_wdata_out,
  input wire [7:0] sfr_rdata_in,
  output wire extra_processor_register_window_stb_out,
  output wire extra_processor_register_window_we_out,
  output wire [11:0] extra_processor_register_window_addr_out,
  output wire [7:0] extra_processor_register_window_wdata_out,
  input wire [7:0] extra_processor_register_window_rdata_in,
  output wire rad_stb_out,
  output wire rad_we_out,
  output wire [11:0] rad_addr_out,
  output wire [7:0] rad_wdata_out,
  input wire [7:0] rad_rdata_in,
  input wire rad_done_in,
  output wire rad_busy_out,
  output wire fl_rd_out,
  output wire [14:0] fl_addr_out,
  input wire [15:0] fl_rdata_in,
  input wire fl_valid_in,
  input wire fl_busy_in,
  output wire fl_prog_out,
  output wire [14:0] fl_waddr_out,
  output wire [15:0] fl_pdata_out,
  output wire fl_erase_out,
  output wire [5:0] fl_page_out
);
  reg [2:0] ack_ff;
  reg [2:0] beat_ff;
  reg [23:0] lo_ff;
  reg [47:0] rdata_ff;
  reg sfr_stb_ff;
  reg sfr_we_ff;
  reg [7:0] sfr_addr_ff;
  reg [7:0] sfr_wdata_ff;
  reg extra_processor_register_window_stb_ff;
  reg extra_processor_register_window_we_ff;
  reg [11:0] extra_processor_register_window_addr_ff;
  reg [7:0] extra_processor_register_window_wdata_ff;
  reg rad_stb_ff;
  reg rad_we_ff;
  reg [11:0] rad_addr_ff;
  reg [7:0] rad_wdata_ff;
  reg rad_busy_ff;
  reg rad_wait_ff;
  reg fl_prog_ff;
  reg [14:0] fl_waddr_ff;
  reg [15:0] fl_pdata_ff;
  reg fl_erase_ff;
  reg [5:0] fl_page_ff;

  reg [15:0] ea [0:2];
  reg [2:0] tg [0:2];
  reg [7:0] wb [0:2];
  reg [15:0] md [0:2];
  reg [2:0] rq;
  reg [2:0] weff;
  reg [2:0] split;
  reg [2:0] mc;
  reg [20:0] treq;
  wire [20:0] gnt;
  reg [15:0] ta [0:6];
  reg [7:0] twb [0:6];
  reg [15:0] twd [0:6];
  reg [6:0] act;
  reg [6:0] twe;
  reg [6:0] tw;
  reg [6:0] comp;
  reg [15:0] c_a;
  reg [2:0] c_t;
  reg [1:0] s;
  reg fl_er;
  reg rad_nb;
  reg rad_issue;
  reg [15:0] rd_fl;
  reg [15:0] rd_sfr;
  reg [15:0] rd_extra_processor_register_window;
  reg [15:0] rd_rad;
  wire [47:0] rd_ram;
  wire [111:0] rd = {rd_rad, rd_extra_processor_register_window, rd_sfr, rd_fl, rd_ram};
  wire c_hit;
  wire [15:0] c_data;
  wire c_idle;
  wire [2:0] wide_v = {1'b1, mst_wide_in};
  wire [2:0] off_v = {1'b0, ram_off_in};
  integer m;
  integer k;
  integer ki;
  integer mj;
  integer kj;
  integer mi;

  function [2:0] mic_dec;
    input [1:0] sp;
    input [15:0] a;
    begin
      mic_dec = `MIC_T_NONE;
      case (sp)
        `MIC_SP_CODE: mic_dec = `MIC_T_FL;
        `MIC_SP_DIR: mic_dec = a[7] ? `MIC_T_SFR : `MIC_T_IRAM;
        `MIC_SP_IND: mic_dec = `MIC_T_IRAM;
        default: begin
          if ((a & `MIC_WIN_MASK) == `MIC_XR0_BASE) mic_dec = `MIC_T_XR0;
          else if ((a & `MIC_WIN_MASK) == `MIC_XR1_BASE) mic_dec = `MIC_T_XR1;
          else if (a >= `MIC_FLX_BASE) mic_dec = `MIC_T_FL;
          else if ((a & `MIC_WIN_MASK) == `MIC_RAD_BASE) mic_dec = `MIC_T_RAD;
          else if ((a & `MIC_WIN_MASK) == `MIC_RADNB_BASE) mic_dec = `MIC_T_RAD;
          else if ((a & `MIC_SFRX_MASK) == `MIC_SFRX_BASE) mic_dec = `MIC_T_SFR;
          else if (a >= `MIC_EXTRA_PROCESSOR_REGISTER_WINDOW_BASE) mic_dec = `MIC_T_EXTRA_PROCESSOR_REGISTER_WINDOW;
        end
      endcase
    end
  endfunction

  function [1:0] sel_idx;
    input [2:0] g;
    sel_idx = g[2] ? 2'h2 : (g[1] ? 2'h1 : 2'h0);
  endfunction

  // per master: effective byte address, target and width of the current beat
  always @* begin
    c_a = 16'h0000;
    c_t = 3'h0;
    for (m = 0; m < 3; m = m + 1) begin
      c_a = mst_addr_in[16*m +: 16] + {15'h0000, beat_ff[m]};
      c_t = mic_dec(mst_space_in[2*m +: 2], c_a);
      ea[m] = c_a;
      tg[m] = c_t;
      // only memories take a word at once, odd or register words go in two beats
      weff[m] = wide_v[m] & ~beat_ff[m] & ~c_a[0] & (c_t <= `MIC_T_FL);
      split[m] = wide_v[m] & ~weff[m];
      wb[m] = beat_ff[m] ? mst_wdata_in[16*m+8 +: 8] : mst_wdata_in[16*m +: 8];
      // the ack cycle masks the request so one request is not taken twice
      rq[m] = mst_req_in[m] & ~ack_ff[m];
      for (k = 0; k < 7; k = k + 1) begin
        treq[3*k+m] = rq[m] & (c_t == k[2:0]);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : arb
      mic_rr_arb u_arb (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .req_in(treq[3*g +: 3]),
        .adv_in(comp[g]),
        .gnt_out(gnt[3*g +: 3])
      );
    end
  endgenerate

  // each target sees only its own winner, so all seven run side by side
  always @* begin
    s = 2'h0;
    for (ki = 0; ki < 7; ki = ki + 1) begin
      s = sel_idx(gnt[3*ki +: 3]);
      act[ki] = |gnt[3*ki +: 3];
      ta[ki] = ea[s];
      twe[ki] = mst_we_in[s];
      tw[ki] = weff[s];
      twb[ki] = wb[s];
      twd[ki] = mst_wdata_in[16*s +: 16];
    end
  end

  generate
    for (g = 0; g < 3; g = g + 1) begin : ram
      localparam AW = (g == 2) ? `MIC_IRAM_AW : `MIC_XRAM_AW;
      reg [15:0] mem [0:(1<<AW)-1];
      wire [AW-1:0] wa = ta[g][AW:1];
      wire off = off_v[g];
      always @(posedge clock_in) begin
        if (act[g] && twe[g] && !off) begin
          if (tw[g]) mem[wa] <= twd[g];
          else if (ta[g][0]) mem[wa][15:8] <= twb[g];
          else mem[wa][7:0] <= twb[g];
        end
      end
      // a block switched off reads zero and drops writes
      assign rd_ram[16*g +: 16] = off ? 16'h0000 :
        (tw[g] ? mem[wa] : {8'h00, (ta[g][0] ? mem[wa][15:8] : mem[wa][7:0])});
    end
  endgenerate

  mic_flash_cache u_cache (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .rd_in(act[3] & ~twe[3]),
    .addr_in(ta[3][15:1]),
    .inval_in(fl_prog_ff | fl_erase_ff),
    .hit_out(c_hit),
    .data_out(c_data),
    .idle_out(c_idle),
    .fl_rd_out(fl_rd_out),
    .fl_addr_out(fl_addr_out),
    .fl_rdata_in(fl_rdata_in),
    .fl_valid_in(fl_valid_in)
  );

  always @* begin
    fl_er = (ta[5] == `MIC_ERASE_REG) & twe[5];
    rad_nb = (ta[6] & `MIC_WIN_MASK) == `MIC_RADNB_BASE;
    rad_issue = act[6] & ~rad_busy_ff & ~rad_wait_ff;
    comp[2:0] = act[2:0];
    // byte writes into flash finish with no effect, only words program
    comp[3] = act[3] & (twe[3] ?
      (~tw[3] | (~fl_busy_in & c_idle & ~fl_prog_ff & ~fl_erase_ff)) : c_hit);
    comp[4] = act[4] & sfr_stb_ff;
    comp[5] = act[5] & (fl_er ? (~fl_busy_in & ~fl_prog_ff & ~fl_erase_ff) : extra_processor_register_window_stb_ff);
    comp[6] = act[6] & (rad_nb ? rad_issue : (rad_wait_ff & rad_done_in));
    rd_fl = tw[3] ? c_data : {8'h00, (ta[3][0] ? c_data[15:8] : c_data[7:0])};
    rd_sfr = {8'h00, sfr_rdata_in};
    rd_extra_processor_register_window = fl_er ? 16'h0000 : {8'h00, extra_processor_register_window_rdata_in};
    rd_rad = rad_nb ? 16'h0000 : {8'h00, rad_rdata_in};
  end

  always @* begin
    for (mj = 0; mj < 3; mj = mj + 1) begin
      mc[mj] = rq[mj] & (tg[mj] == `MIC_T_NONE);
      md[mj] = 16'h0000;
      for (kj = 0; kj < 7; kj = kj + 1) begin
        if (gnt[3*kj+mj] && comp[kj]) begin
          mc[mj] = 1'b1;
          md[mj] = rd[16*kj +: 16];
        end
      end
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_ff <= 3'h0;
      beat_ff <= 3'h0;
      lo_ff <= 24'h000000;
      rdata_ff <= 48'h000000000000;
      sfr_stb_ff <= 1'b0;
      sfr_we_ff <= 1'b0;
      sfr_addr_ff <= 8'h00;
      sfr_wdata_ff <= 8'h00;
      extra_processor_register_window_stb_ff <= 1'b0;
      extra_processor_register_window_we_ff <= 1'b0;
      extra_processor_register_window_addr_ff <= 12'h000;
      extra_processor_register_window_wdata_ff <= 8'h00;
      rad_stb_ff <= 1'b0;
      rad_we_ff <= 1'b0;
      rad_addr_ff <= 12'h000;
      rad_wdata_ff <= 8'h00;
      rad_busy_ff <= 1'b0;
      rad_wait_ff <= 1'b0;
      fl_prog_ff <= 1'b0;
      fl_waddr_ff <= 15'h0000;
      fl_pdata_ff <= 16'h0000;
      fl_erase_ff <= 1'b0;
      fl_page_ff <= 6'h00;
    end else begin
      sfr_stb_ff <= act[4] & ~sfr_stb_ff;
      if (act[4] && !sfr_stb_ff) begin
        sfr_we_ff <= twe[4];
        sfr_addr_ff <= ta[4][7:0];
        sfr_wdata_ff <= twb[4];
      end
      extra_processor_register_window_stb_ff <= act[5] & ~fl_er & ~extra_processor_register_window_stb_ff;
      if (act[5] && !fl_er && !extra_processor_register_window_stb_ff) begin
        extra_processor_register_window_we_ff <= twe[5];
        extra_processor_register_window_addr_ff <= ta[5][11:0];
        extra_processor_register_window_wdata_ff <= twb[5];
      end
      rad_stb_ff <= rad_issue;
      if (rad_issue) begin
        rad_we_ff <= twe[6];
        rad_addr_ff <= ta[6][11:0];
        rad_wdata_ff <= twb[6];
      end
      rad_busy_ff <= rad_issue | (rad_busy_ff & ~rad_done_in);
      rad_wait_ff <= (rad_issue & ~rad_nb) | (rad_wait_ff & ~rad_done_in);
      fl_prog_ff <= comp[3] & twe[3] & tw[3];
      if (comp[3] && twe[3] && tw[3]) begin
        fl_waddr_ff <= ta[3][15:1];
        fl_pdata_ff <= twd[3];
      end
      fl_erase_ff <= comp[5] & fl_er;
      if (comp[5] && fl_er) fl_page_ff <= twb[5][`MIC_PAGE_W-1:0];
      ack_ff <= 3'h0;
      for (mi = 0; mi < 3; mi = mi + 1) begin
        if (mc[mi]) begin
          if (split[mi] && !beat_ff[mi]) begin
            beat_ff[mi] <= 1'b1;
            lo_ff[8*mi +: 8] <= md[mi][7:0];
          end else begin
            ack_ff[mi] <= 1'b1;
            beat_ff[mi] <= 1'b0;
            rdata_ff[16*mi +: 16] <= split[mi] ? {md[mi][7:0], lo_ff[8*mi +: 8]} : md[mi];
          end
        end
      end
    end
  end

  assign mst_ack_out = ack_ff;
  assign mst_rdata_out = rdata_ff;
  assign sfr_stb_out = sfr_stb_ff;
  assign sfr_we_out = sfr_we_ff;
  assign sfr_addr_out = sfr_addr_ff;
  assign sfr_wdata_out = sfr_wdata_ff;
  assign extra_processor_register_window_stb_out = extra_processor_register_window_stb_ff;
  assign extra_processor_register_window_we_out = extra_processor_register_window_we_ff;
  assign extra_processor_register_window_addr_out = extra_processor_register_window_addr_ff;
  assign extra_processor_register_window_wdata_out = extra_processor_register_window_wdata_ff;
  assign rad_stb_out = rad_stb_ff;
  assign rad_we_out = rad_we_ff;
  assign rad_addr_out = rad_addr_ff;
  assign rad_wdata_out = rad_wdata_ff;
  assign rad_busy_out = rad_busy_ff;
  assign fl_prog_out = fl_prog_ff;
  assign fl_waddr_out = fl_waddr_ff;
  assign fl_pdata_out = fl_pdata_ff;
  assign fl_erase_out = fl_erase_ff;
  assign fl_page_out = fl_page_ff;
endmodule // mic_interconnect
`default_nettype wire

// file: mic_interconnect_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module mic_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [2:0] mst_req_in,
  input wire logic [2:0] mst_ack_out,
  input wire logic rad_stb_out,
  input wire logic rad_done_in,
  input wire logic rad_busy_out,
  input wire logic fl_rd_out,
  input wire logic fl_busy_in,
  input wire logic fl_prog_out,
  input wire logic fl_erase_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_ack_one_pulse: assert property (mst_ack_out[0] |=> !mst_ack_out[0])
    else $error("cpu ack longer than one cycle");
  a_ack_needs_req: assert property (mst_ack_out[1] |-> $past(mst_req_in[1]))
    else $error("dma ack without request");
  a_aes_served: assert property ($rose(mst_req_in[2]) |-> ##[1:300] mst_ack_out[2])
    else $error("aes request starved");
  a_cpu_waits_grant: assert property (mst_req_in[0] |-> ##[0:300] mst_ack_out[0])
    else $error("cpu request never granted");
  a_rad_stb_busy: assert property (rad_stb_out |-> rad_busy_out)
    else $error("radio strobe without busy");
  a_rad_busy_hold: assert property (rad_busy_out && !rad_done_in |=> rad_busy_out)
    else $error("radio busy dropped before done");
  a_fl_rd_single: assert property (fl_rd_out |=> !fl_rd_out)
    else $error("flash fetch overlapped");
  a_prog_when_idle: assert property (fl_prog_out |-> !fl_busy_in && !$past(fl_busy_in))
    else $error("program while flash busy");
  a_erase_when_idle: assert property (fl_erase_out |-> !fl_busy_in)
    else $error("erase while flash busy");
endmodule // mic_checker
bind mic_interconnect mic_checker u_chk (.clock_in, .rst_n_in, .mst_req_in, .mst_ack_out,
  .rad_stb_out, .rad_done_in, .rad_busy_out, .fl_rd_out, .fl_busy_in, .fl_prog_out,
  .fl_erase_out);
`default_nettype wire

// file: mic_tgt_model.sv
`timescale 1ns/10ps
`default_nettype none
module mic_tgt_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic [7:0] sfr_addr_out,
  input wire logic [11:0] extra_processor_register_window_addr_out,
  input wire logic rad_stb_out,
  input wire logic [11:0] rad_addr_out,
  input wire logic fl_rd_out,
  input wire logic [14:0] fl_addr_out,
  input wire logic fl_prog_out,
  input wire logic [14:0] fl_waddr_out,
  input wire logic [15:0] fl_pdata_out,
  input wire logic fl_erase_out,
  input wire logic [5:0] fl_page_out,
  output logic [7:0] sfr_rdata_in,
  output logic [7:0] extra_processor_register_window_rdata_in,
  output logic [7:0] rad_rdata_in,
  output logic rad_done_in,
  output logic [15:0] fl_rdata_in,
  output logic fl_valid_in,
  output logic fl_busy_in
);
  logic [15:0] mem [0:32767];
  logic [3:0] rcnt, fcnt, bcnt;
  logic [14:0] fa;
  logic [7:0] ra;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'(i) ^ 16'hC3A5;
  end
  assign sfr_rdata_in = sfr_addr_out ^ 8'h5A;
  assign extra_processor_register_window_rdata_in = extra_processor_register_window_addr_out[7:0] ^ 8'h3C;
  assign fl_busy_in = (bcnt != 4'h0);
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rcnt <= 4'h0;
      fcnt <= 4'h0;
      bcnt <= 4'h0;
      rad_done_in <= 1'b0;
      fl_valid_in <= 1'b0;
      rad_rdata_in <= 8'h00;
      fl_rdata_in <= 16'h0000;
    end else begin
      // data is only good with its pulse; otherwise it keeps changing
      rad_done_in <= (rcnt == 4'h1);
      rad_rdata_in <= (rcnt == 4'h1) ? ra ^ 8'hC3 : ~rad_rdata_in;
      fl_valid_in <= (fcnt == 4'h1);
      fl_rdata_in <= (fcnt == 4'h1) ? mem[fa] : ~fl_rdata_in;
      if (rad_stb_out) begin
        ra <= rad_addr_out[7:0];
        rcnt <= slow_in ? 4'h6 : 4'h1;
      end else if (rcnt != 4'h0) begin
        rcnt <= rcnt - 4'h1;
      end
      if (fl_rd_out) begin
        fa <= fl_addr_out;
        fcnt <= slow_in ? 4'h5 : 4'h1;
      end else if (fcnt != 4'h0) begin
        fcnt <= fcnt - 4'h1;
      end
      if (fl_prog_out) begin
        mem[fl_waddr_out] <= fl_pdata_out;
        bcnt <= 4'h4;
      end else if (fl_erase_out) begin
        for (int i = 0; i < 512; i++) mem[{fl_page_out, 9'h000} + i] <= 16'hFFFF;
        bcnt <= 4'h8;
      end else if (bcnt != 4'h0) begin
        bcnt <= bcnt - 4'h1;
      end
    end
  end
endmodule // mic_tgt_model
`default_nettype wire

// file: memory_interconnect_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module memory_interconnect_decoder_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic slow_in = 1'b0;
  logic [2:0] mst_req_in = 3'h0;
  logic [2:0] mst_we_in = 3'h0;
  logic [1:0] mst_wide_in = 2'h0;
  logic [1:0] ram_off_in = 2'h0;
  logic [5:0] mst_space_in = 6'h00;
  logic [47:0] mst_addr_in = 48'h0;
  logic [47:0] mst_wdata_in = 48'h0;
  wire [2:0] mst_ack_out;
  wire [47:0] mst_rdata_out;
  wire sfr_stb_out, sfr_we_out, extra_processor_register_window_stb_out, extra_processor_register_window_we_out, rad_stb_out, rad_we_out;
  wire rad_done_in, rad_busy_out, fl_rd_out, fl_valid_in, fl_busy_in, fl_prog_out, fl_erase_out;
  wire [7:0] sfr_addr_out, sfr_wdata_out, sfr_rdata_in, extra_processor_register_window_wdata_out, extra_processor_register_window_rdata_in;
  wire [7:0] rad_wdata_out, rad_rdata_in;
  wire [11:0] extra_processor_register_window_addr_out, rad_addr_out;
  wire [14:0] fl_addr_out, fl_waddr_out;
  wire [15:0] fl_rdata_in, fl_pdata_out;
  wire [5:0] fl_page_out;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int i, m;
  int lat [3];
  logic [15:0] rv [3];
  logic [15:0] a, d, e;
  logic [31:0] lf = 32'h0001611E;
  logic wd;
  mic_interconnect dut (.*);
  mic_tgt_model u_far (.*);
  always #50 clock_in = ~clock_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] flw(input logic [15:0] b);
    return {1'b0, b[15:1]} ^ 16'hC3A5;
  endfunction
  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held steady until ack, dropped in the ack cycle
  task automatic acc(input int k, input logic we, w, input logic [1:0] sp,
                     input logic [15:0] ad, dt);
    int n;
    @(negedge clock_in);
    mst_req_in[k] = 1'b1;
    mst_we_in[k] = we;
    if (k < 2) mst_wide_in[k] = w;
    mst_space_in[2*k+:2] = sp;
    mst_addr_in[16*k+:16] = ad;
    mst_wdata_in[16*k+:16] = dt;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (mst_ack_out[k] !== 1'b1 && n < 400);
    rv[k] = mst_rdata_out[16*k+:16];
    lat[k] = n;
    mst_req_in[k] = 1'b0;
    if (n >= 400) n_mismatch++;
  endtask
  task automatic rdc(input int k, input logic w, input logic [1:0] sp,
                     input logic [15:0] ad, exp, input string nm);
    acc(k, 1'b0, w, sp, ad, 16'h0000);
    chk(nm, rv[k], exp);
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge clock_in);
    @(negedge clock_in);
    rst_n_in = 1'b1;
    chk("rdata_rst", mst_rdata_out[15:0], 16'h0000);
    for (i = 0; i < 40; i++) begin
      lf = lfsr(lf);
      m = lf[1:0] % 3;
      wd = (m == 2) | lf[2];
      a = {3'h0, lf[15:3]} % 16'h1FFF;
      d = lf[31:16];
      acc(m, 1'b1, wd, 2'h1, a, d);
      rdc(m, wd, 2'h1, a, wd ? d : {8'h00, d[7:0]}, "xram");
    end
    acc(1, 1'b1, 1'b1, 2'h1, 16'h0FFF, 16'hA55A);
    rdc(0, 1'b0, 2'h1, 16'h1000, 16'h00A5, "split");
    fork
      acc(0, 1'b1, 1'b0, 2'h1, 16'h0040, 16'h0011);
      acc(1, 1'b1, 1'b0, 2'h1, 16'h1040, 16'h0022);
      acc(2, 1'b1, 1'b1, 2'h3, 16'h0050, 16'h3344);
    join
    chk("parallel", 16'(lat[0] + lat[1] + lat[2]), 16'h0003);
    // all three on one ram: acks must land in three different cycles
    fork
      acc(0, 1'b1, 1'b0, 2'h1, 16'h0041, 16'h0055);
      acc(1, 1'b1, 1'b0, 2'h1, 16'h0042, 16'h0066);
      acc(2, 1'b1, 1'b1, 2'h1, 16'h0044, 16'h7788);
    join
    chk("contend", 16'(lat[0] + lat[1] + lat[2] + 10 * lat[0] * lat[1] * lat[2]), 16'h0042);
    rdc(2, 1'b1, 2'h1, 16'h0040, 16'h5511, "rr_data");
    rdc(1, 1'b0, 2'h1, 16'h0042, 16'h0066, "rr_data");
    rdc(0, 1'b1, 2'h1, 16'h0044, 16'h7788, "rr_data");
    rdc(1, 1'b1, 2'h3, 16'h0050, 16'h3344, "iram_w");
    ram_off_in = 2'h2;
    rdc(0, 1'b0, 2'h1, 16'h1040, 16'h0000, "ram_off");
    rdc(1, 1'b0, 2'h1, 16'h0040, 16'h0011, "ram_on");
    ram_off_in = 2'h0;
    acc(0, 1'b1, 1'b0, 2'h3, 16'h0090, 16'h0066);
    rdc(0, 1'b0, 2'h2, 16'h0090, 16'h00CA, "direct");
    rdc(1, 1'b0, 2'h3, 16'h0090, 16'h0066, "indirect");
    rdc(0, 1'b0, 2'h1, 16'h7090, 16'h00CA, "sfr_x");
    acc(0, 1'b1, 1'b0, 2'h2, 16'h0085, 16'h0077);
    chk("sfr_w", {sfr_addr_out, sfr_wdata_out}, 16'h8577);
    chk("sfr_we", {15'h0000, sfr_we_out}, 16'h0001);
    rdc(1, 1'b0, 2'h1, 16'h7123, 16'h001F, "extra_processor_register_window");
    acc(1, 1'b1, 1'b0, 2'h1, 16'h7123, 16'h0044);
    chk("extra_processor_register_window_w", {extra_processor_register_window_addr_out[7:0], extra_processor_register_window_wdata_out}, 16'h2344);
    chk("extra_processor_register_window_we", {15'h0000, extra_processor_register_window_we_out}, 16'h0001);
    acc(0, 1'b1, 1'b0, 2'h1, 16'h2345, 16'h0099);
    rdc(0, 1'b0, 2'h1, 16'h2345, 16'h0000, "unmapped");
    rdc(1, 1'b0, 2'h1, 16'h6000, 16'h0000, "unmapped");
    slow_in = 1'b1;
    rdc(0, 1'b0, 2'h1, 16'h4012, 16'h00D1, "radio");
    rdc(1, 1'b0, 2'h1, 16'h4FFF, 16'h003C, "radio_top");
    acc(0, 1'b1, 1'b0, 2'h1, 16'h5012, 16'h0001);
    chk("nb_lat", 16'(lat[0]), 16'h0001);
    chk("rad_w", {rad_addr_out[7:0], rad_wdata_out}, 16'h1201);
    chk("rad_we", {15'h0000, rad_we_out}, 16'h0001);
    rdc(1, 1'b0, 2'h1, 16'h5013, 16'h0000, "nb_read");
    rdc(0, 1'b1, 2'h0, 16'h0100, flw(16'h0100), "code");
    rdc(0, 1'b1, 2'h0, 16'h0100, flw(16'h0100), "code_hit");
    chk("hit_lat", 16'(lat[0]), 16'h0001);
    rdc(2, 1'b1, 2'h0, 16'h0102, flw(16'h0102), "aes_code");
    rdc(1, 1'b1, 2'h1, 16'h8100, flw(16'h8100), "flash_x");
    e = flw(16'h8100);
    rdc(1, 1'b0, 2'h1, 16'h8101, {8'h00, e[15:8]}, "flash_xb");
    acc(0, 1'b1, 1'b1, 2'h0, 16'h0200, 16'hBEEF);
    rdc(1, 1'b1, 2'h0, 16'h0200, 16'hBEEF, "prog");
    acc(2, 1'b1, 1'b1, 2'h1, 16'h8202, 16'h1357);
    rdc(0, 1'b1, 2'h0, 16'h8202, 16'h1357, "prog_x");
    // erase page 1 only; page 2 right above it is read back and must stay untouched
    acc(1, 1'b1, 1'b0, 2'h1, 16'h7F00, 16'h0001);
    rdc(0, 1'b1, 2'h0, 16'h0400, 16'hFFFF, "erased");
    rdc(2, 1'b1, 2'h0, 16'h0800, flw(16'h0800), "kept");
    test_done();
  end
endmodule // memory_interconnect_decoder_tb
`default_nettype wire
